// >>> include/cbs_regs.svh
// constants of the configuration bitstream source
// assumes a 50 MHz system clock that also paces the configuration stream
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

// ****************************************
// capacities in configuration bits
// ****************************************
`define CBS_CAP_SER_MIN_BITS 1048576
`define CBS_CAP_PAR_MIN_BITS 8388608
`define CBS_CAP_MAX_BITS 33554432
`define CBS_BITS_PER_BYTE 8
`define CBS_NUM_REVS 4

// ****************************************
// timing
// ****************************************
`define CBS_SYS_CLK_KHZ 50000
`define CBS_MAX_RATE_KHZ 33000
// least half period of the driven clock, rounded up, at least one cycle
`define CBS_CLK_HALF_CYC ((`CBS_SYS_CLK_KHZ + 2 * `CBS_MAX_RATE_KHZ - 1) / (2 * `CBS_MAX_RATE_KHZ))

// ****************************************
// reset values
// ****************************************
`define CBS_RST_BYTE 8'h00
`define CBS_RST_BIT_IDX 3'h0

`endif

// >>> include/cbs_pkg.sv
// types of the configuration bitstream source
// assumes cbs_regs.svh on the include path
package cbs_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} cbs_state_t;
  typedef logic [22:0] cbs_bptr_t;

  typedef struct packed {
    cbs_state_t state;
    cbs_bptr_t ptr;
    cbs_bptr_t end_ptr;
    logic [2:0] bit_idx;
    logic [7:0] shreg;
    logic [7:0] data;
    logic sdata;
    logic [3:0] div_cnt;
    logic receiver_config_clock;
  } cbs_src_t;

  typedef struct packed {
    logic [7:0] run_left;
    logic [7:0] run_val;
  } cbs_exp_t;
endpackage : cbs_pkg

// >>> src/cbs_expand.sv
// run-length expander between the store and the output stage
// assumes the caller shows the bytes at the read pointer and the one after
`timescale 1ns/10ps
`default_nettype none

module cbs_expand (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clear,
  input wire logic i_step,
  input wire logic i_comp,
  input wire logic [7:0] i_byte0,
  input wire logic [7:0] i_byte1,
  output logic [7:0] o_byte,
  output logic [1:0] o_fetch,
  output logic o_running
);
  import cbs_pkg::*;

  cbs_exp_t r_reg;
  cbs_exp_t r_next;

  // ****************************************
  // expansion
  // ****************************************
  always_comb begin
    r_next = r_reg;
    o_byte = i_byte0;
    o_fetch = 2'h1;
    o_running = i_comp && (r_reg.run_left != 8'h00);
    if (i_comp) begin
      if (r_reg.run_left != 8'h00) begin
        o_byte = r_reg.run_val;
        o_fetch = 2'h0;
        if (i_step) begin
          r_next.run_left = r_reg.run_left - 8'h01;
        end
      end else begin
        o_byte = i_byte1;
        o_fetch = 2'h2;
        if (i_step) begin
          r_next.run_left = i_byte0;
          r_next.run_val = i_byte1;
        end
      end
    end
    if (i_clear) begin
      r_next = '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_run_load: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_step && i_comp && !i_clear && r_reg.run_left == 8'h00)
    |=> (r_reg.run_left == $past(i_byte0) && r_reg.run_val == $past(i_byte1)))
    else $error("run not loaded from stored pair");
  chk_run_count: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_step && i_comp && !i_clear && r_reg.run_left != 8'h00)
    |=> (r_reg.run_left == $past(r_reg.run_left) - 8'h01))
    else $error("run count not decremented");
  cov_run: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_step && i_comp && o_running);
endmodule : cbs_expand

`default_nettype wire

// >>> src/cbs_source.sv
// configuration bitstream source: store, read pointer, serial and byte output
// assumes every input is synchronous to i_clk_sys, the configuration clock
// How it works
// - serial: enabled with request high gives first bit
// - next word after every qualifying rising edge
// - external clock, or store drives receiver clock
// - parallel: busy low, request high, drive bytes
// - driven clock rate capped at stated maximum
// - address range spans every density
// - revision from pins or internal bits
// - compressed images expanded before output
// - cascade enable out hands on to next
// - revisions/compression across chain need parallel parts
// - smallest parallel part revisions only cascaded
// - programming ignores all configuration inputs
`include "cbs_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module cbs_source #(
  parameter int P_CAP_BITS = `CBS_CAP_MAX_BITS
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_chip_enable_n,
  input wire logic i_output_enable,
  input wire logic i_config_request_n,
  input wire logic i_busy,
  input wire logic i_parallel_mode,
  input wire logic i_drive_clock_en,
  input wire logic i_rev_enable,
  input wire logic i_ext_rev_sel_en,
  input wire logic [1:0] i_rev_sel,
  input wire logic [1:0] i_rev_ctrl,
  input wire logic i_compress_en,
  input wire logic i_cascaded,
  input wire logic i_chain_all_parallel,
  input wire logic i_prog_active,
  input wire logic i_prog_write,
  input wire cbs_pkg::cbs_bptr_t i_prog_addr,
  input wire logic [7:0] i_prog_data,
  output logic o_serial_data_out,
  output logic [7:0] o_data,
  output logic o_data_en_n,
  output logic o_cascade_enable_out_n,
  output logic o_receiver_config_clock
);
  import cbs_pkg::*;

  // ****************************************
  // constants
  // ****************************************
  // byte pointer sized for largest
  localparam cbs_bptr_t CAP_BYTES = cbs_bptr_t'(P_CAP_BITS / `CBS_BITS_PER_BYTE);
  localparam cbs_bptr_t REV_BYTES = cbs_bptr_t'(P_CAP_BITS / `CBS_BITS_PER_BYTE / `CBS_NUM_REVS);
  localparam logic PAR_CAPABLE = (P_CAP_BITS >= `CBS_CAP_PAR_MIN_BITS);
  localparam logic PAR_SMALLEST = (P_CAP_BITS == `CBS_CAP_PAR_MIN_BITS);
  localparam logic [3:0] HALF_CYC = 4'(`CBS_CLK_HALF_CYC);
  localparam int MEM_DEPTH = `CBS_CAP_MAX_BITS / `CBS_BITS_PER_BYTE;

  localparam cbs_src_t RST = '{
    state: ST_IDLE, ptr: '0, end_ptr: CAP_BYTES, bit_idx: `CBS_RST_BIT_IDX,
    shreg: `CBS_RST_BYTE, data: `CBS_RST_BYTE, sdata: 1'b0, div_cnt: 4'h0, receiver_config_clock: 1'b0};

  logic [7:0] mem [MEM_DEPTH];

  cbs_src_t r_reg;
  cbs_src_t r_next;

  logic en;
  logic par_q;
  logic rev_ok;
  logic comp_ok;
  logic clk_rise;
  logic qualify;
  logic need_byte;
  logic ending;
  logic step_go;
  logic restart;
  logic [1:0] rev;
  cbs_bptr_t base;
  cbs_bptr_t len;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [7:0] exp_byte;
  logic [1:0] fetch;
  logic exp_running;

  // ****************************************
  // store
  // ****************************************
  assign byte0 = mem[r_reg.ptr[21:0]];
  assign byte1 = mem[r_reg.ptr[21:0] + 22'h1];

  always_ff @(posedge i_clk_sys) begin
    if (i_prog_active && i_prog_write) begin
      mem[i_prog_addr[21:0]] <= i_prog_data;
    end
  end

  // ****************************************
  // mode qualification
  // ****************************************
  always_comb begin
    en = !i_chip_enable_n && i_output_enable && !i_prog_active;
    restart = !i_config_request_n && !i_prog_active;
    par_q = i_parallel_mode && PAR_CAPABLE;
    rev_ok = i_rev_enable && PAR_CAPABLE && !(PAR_SMALLEST && !i_cascaded)
      && (!i_cascaded || i_chain_all_parallel);
    comp_ok = i_compress_en && PAR_CAPABLE && (!i_cascaded || i_chain_all_parallel);
    rev = i_ext_rev_sel_en ? i_rev_sel : i_rev_ctrl;
    len = rev_ok ? REV_BYTES : CAP_BYTES;
    base = rev_ok ? cbs_bptr_t'(REV_BYTES * rev) : '0;
    // driven clock at most max rate
    clk_rise = i_drive_clock_en && (r_reg.div_cnt == HALF_CYC - 4'h1) && !r_reg.receiver_config_clock;
    qualify = en && i_config_request_n && (!par_q || !i_busy)
      && (!i_drive_clock_en || clk_rise);
    need_byte = par_q || (r_reg.bit_idx == 3'h0);
    ending = need_byte && !exp_running && (r_reg.ptr >= r_reg.end_ptr);
    step_go = qualify && (r_reg.state != ST_DONE) && !ending;
  end

  cbs_expand u_expand (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_clear(restart),
    .i_step(step_go && need_byte),
    .i_comp(comp_ok),
    .i_byte0(byte0),
    .i_byte1(byte1),
    .o_byte(exp_byte),
    .o_fetch(fetch),
    .o_running(exp_running)
  );

  // ****************************************
  // output stage
  // ****************************************
  always_comb begin
    r_next = r_reg;
    if (i_drive_clock_en && !i_prog_active) begin
      if (r_reg.div_cnt == HALF_CYC - 4'h1) begin
        r_next.div_cnt = 4'h0;
        r_next.receiver_config_clock = !r_reg.receiver_config_clock;
      end else begin
        r_next.div_cnt = r_reg.div_cnt + 4'h1;
      end
    end
    if (restart) begin
      r_next.state = ST_IDLE;
      r_next.ptr = base;
      r_next.end_ptr = base + len;
      r_next.bit_idx = 3'h0;
    end else if (qualify && r_reg.state != ST_DONE && ending) begin
      r_next.state = ST_DONE;
    end else if (step_go) begin
      r_next.state = ST_RUN;
      if (need_byte) begin
        r_next.ptr = r_reg.ptr + {21'h0, fetch};
        if (par_q) begin
          r_next.data = exp_byte;
        end else begin
          r_next.sdata = exp_byte[7];
          r_next.shreg = {exp_byte[6:0], 1'b0};
          r_next.bit_idx = 3'h1;
        end
      end else begin
        r_next.sdata = r_reg.shreg[7];
        r_next.shreg = {r_reg.shreg[6:0], 1'b0};
        r_next.bit_idx = r_reg.bit_idx + 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_data = r_reg.data;
  assign o_serial_data_out = r_reg.sdata;
  assign o_data_en_n = !en;
  assign o_receiver_config_clock = r_reg.receiver_config_clock;
  assign o_cascade_enable_out_n = i_prog_active || i_chip_enable_n || (r_reg.state != ST_DONE);

  // ****************************************
  // checks
  // ****************************************
  chk_first_bit: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (r_reg.state == ST_IDLE && step_go && !par_q && !restart)
    |=> (r_reg.sdata == $past(exp_byte[7]) && r_reg.bit_idx == 3'h1))
    else $error("first serial bit not presented");
  chk_next_bit: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (step_go && !need_byte && !restart) |=> (r_reg.sdata == $past(r_reg.shreg[7])))
    else $error("next serial bit wrong");
  chk_byte_out: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (step_go && par_q && !restart) |=> (o_data == $past(exp_byte)))
    else $error("parallel byte not presented");
  chk_ptr_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (!qualify && !restart) |=> $stable(r_reg.ptr))
    else $error("pointer moved while not qualified");
  chk_ptr_step: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (step_go && need_byte && !restart) |=> (r_reg.ptr == $past(r_reg.ptr) + {21'h0, $past(fetch)}))
    else $error("pointer step wrong");
  chk_prog_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_prog_active |-> (o_cascade_enable_out_n && o_data_en_n) ##1 $stable(r_reg.ptr))
    else $error("configuration side active during programming");
  chk_clk_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_drive_clock_en && !i_prog_active && r_reg.div_cnt == HALF_CYC - 4'h1)
    |=> (o_receiver_config_clock != $past(o_receiver_config_clock)))
    else $error("driven clock did not toggle");
  chk_cascade: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (qualify && ending && r_reg.state != ST_DONE && !restart)
    |=> (r_reg.state == ST_DONE
      && (o_cascade_enable_out_n == (i_chip_enable_n || i_prog_active))))
    else $error("cascade enable not handed on");
  chk_rev_base: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    restart |=> (r_reg.ptr == $past(base) && r_reg.end_ptr == $past(base) + $past(len)))
    else $error("revision base not loaded");
  chk_range: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    r_reg.end_ptr <= CAP_BYTES)
    else $error("image end beyond capacity");
  cov_serial_done: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !par_q && r_reg.state == ST_DONE);
  cov_par_step: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    step_go && par_q);
  cov_rev_load: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    restart && rev_ok && rev == 2'h3);
  cov_busy_hold: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    en && par_q && i_busy && r_reg.state == ST_RUN);
endmodule : cbs_source

`default_nettype wire

// >>> verification/cbs_receiver_model.sv
// receiver model: configuration port of the logic device fed by the store
// assumes the bench clock stands for the receiver or oscillator clock
`timescale 1ns/10ps
`default_nettype none

module cbs_receiver_model (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_active,
  input wire logic i_stall,
  input wire logic [7:0] i_data,
  output logic o_busy,
  output logic [7:0] o_word
);
  // ****************************************
  // capture
  // ****************************************
  // capture next edge
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_word <= 8'h00;
    end else if (i_active) begin
      o_word <= i_data;
    end
  end

  assign o_busy = i_stall;
endmodule : cbs_receiver_model

`default_nettype wire

// >>> verification/cbs_source_test.sv
// bench of the configuration bitstream source
// assumes cbs_regs.svh on the include path and the receiver model
`include "cbs_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module cbs_source_test;
  import cbs_pkg::*;
  logic clk;
  logic rst_n = 1'b0;
  logic ce_n = 1'b1;
  logic oe = 1'b0;
  logic req_n = 1'b1;
  logic par = 1'b0;
  logic drv = 1'b0;
  logic rev_en = 1'b0;
  logic ext_en = 1'b0;
  logic [1:0] rev_sel = 2'h0;
  logic [1:0] rev_ctrl = 2'h0;
  logic comp = 1'b0;
  logic casc = 1'b0;
  logic allpar = 1'b0;
  logic pa = 1'b0;
  logic pw = 1'b0;
  cbs_bptr_t paddr = '0;
  logic [7:0] pdata = 8'h00;
  logic stall = 1'b0;
  logic busy;
  logic sdo;
  logic den_n;
  logic ceo_n;
  logic rclk;
  logic [7:0] dout;
  logic [7:0] word;
  logic sdo2;
  logic ceo2_n;
  int num_errors = 0;
  int num_checks = 0;

  cbs_source #(.P_CAP_BITS(`CBS_CAP_PAR_MIN_BITS)) cbs_source_inst (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_chip_enable_n(ce_n), .i_output_enable(oe),
    .i_config_request_n(req_n), .i_busy(busy), .i_parallel_mode(par),
    .i_drive_clock_en(drv), .i_rev_enable(rev_en), .i_ext_rev_sel_en(ext_en),
    .i_rev_sel(rev_sel), .i_rev_ctrl(rev_ctrl), .i_compress_en(comp),
    .i_cascaded(casc), .i_chain_all_parallel(allpar), .i_prog_active(pa),
    .i_prog_write(pw), .i_prog_addr(paddr), .i_prog_data(pdata),
    .o_serial_data_out(sdo), .o_data(dout), .o_data_en_n(den_n),
    .o_cascade_enable_out_n(ceo_n), .o_receiver_config_clock(rclk));

  // eight-byte image so the end of image is reachable
  cbs_source #(.P_CAP_BITS(64)) cbs_source_tiny_inst (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_chip_enable_n(ce_n), .i_output_enable(oe),
    .i_config_request_n(req_n), .i_busy(busy), .i_parallel_mode(par),
    .i_drive_clock_en(drv), .i_rev_enable(rev_en), .i_ext_rev_sel_en(ext_en),
    .i_rev_sel(rev_sel), .i_rev_ctrl(rev_ctrl), .i_compress_en(comp),
    .i_cascaded(casc), .i_chain_all_parallel(allpar), .i_prog_active(pa),
    .i_prog_write(pw), .i_prog_addr(paddr), .i_prog_data(pdata),
    .o_serial_data_out(sdo2), .o_data(), .o_data_en_n(),
    .o_cascade_enable_out_n(ceo2_n), .o_receiver_config_clock());

  cbs_receiver_model cbs_receiver_model_inst (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_active(~ce_n), .i_stall(stall),
    .i_data(dout), .o_busy(busy), .o_word(word));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick;
    @(posedge clk);
    @(negedge clk);
  endtask : tick

  task automatic prog(input cbs_bptr_t a, input logic [7:0] d);
    pa = 1'b1;
    pw = 1'b1;
    paddr = a;
    pdata = 8'hff;
    tick;
    check(cbs_source_inst.mem[a[21:0]], 8'hff);
    pdata = d;
    tick;
    check(cbs_source_inst.mem[a[21:0]], d);
  endtask : prog

  task automatic prog_end;
    pw = 1'b0;
    pa = 1'b0;
  endtask : prog_end

  task automatic restart;
    req_n = 1'b0;
    tick;
    req_n = 1'b1;
  endtask : restart

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_serial;
    logic [15:0] bits;
    bits = 16'ha53d;
    prog(23'h0, 8'ha5);
    prog(23'h1, 8'h3d);
    prog(23'h2, 8'hc3);
    prog_end;
    ce_n = 1'b0;
    oe = 1'b1;
    restart;
    check({7'h0, den_n}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      if (i == 5) begin
        ce_n = 1'b1;
        repeat (3) tick;
        check({7'h0, sdo}, {7'h0, bits[11]});
        ce_n = 1'b0;
      end
      tick;
      check({7'h0, sdo}, {7'h0, bits[15 - i]});
    end
    $display("serial test done");
  endtask : t_serial

  task automatic t_parallel;
    par = 1'b1;
    restart;
    tick;
    check(dout, 8'ha5);
    stall = 1'b1;
    repeat (2) tick;
    check(dout, 8'ha5);
    check(word, 8'ha5);
    stall = 1'b0;
    tick;
    check(dout, 8'h3d);
    tick;
    check(dout, 8'hc3);
    check(word, 8'h3d);
    pa = 1'b1;
    #1;
    check({7'h0, den_n}, 8'h01);
    check({7'h0, ceo_n}, 8'h01);
    repeat (2) tick;
    check(dout, 8'hc3);
    pa = 1'b0;
    $display("parallel test done");
  endtask : t_parallel

  task automatic t_clock;
    int toggles;
    logic last;
    toggles = 0;
    ce_n = 1'b1;
    drv = 1'b1;
    last = rclk;
    for (int i = 0; i < 8; i++) begin
      tick;
      if (rclk !== last) begin
        toggles++;
      end
      last = rclk;
    end
    check(8'(toggles), 8'(8 / `CBS_CLK_HALF_CYC));
    ce_n = 1'b0;
    restart;
    tick;
    check(dout, 8'hc3);
    tick;
    check(dout, 8'ha5);
    tick;
    check(dout, 8'ha5);
    tick;
    check(dout, 8'h3d);
    drv = 1'b0;
    $display("clock test done");
  endtask : t_clock

  task automatic t_revision;
    for (int r = 1; r < 4; r++) begin
      prog(cbs_bptr_t'(r * (`CBS_CAP_PAR_MIN_BITS / 32)), 8'(8'h50 + r));
    end
    prog_end;
    casc = 1'b1;
    allpar = 1'b1;
    rev_en = 1'b1;
    for (int s = 0; s < 2; s++) begin
      for (int r = 0; r < 4; r++) begin
        ext_en = s[0];
        rev_sel = s[0] ? 2'(r) : ~2'(r);
        rev_ctrl = s[0] ? ~2'(r) : 2'(r);
        restart;
        tick;
        check(dout, (r == 0) ? 8'ha5 : 8'(8'h50 + r));
      end
    end
    casc = 1'b0;
    rev_sel = 2'h2;
    restart;
    tick;
    check(dout, 8'ha5);
    rev_en = 1'b0;
    allpar = 1'b0;
    $display("revision test done");
  endtask : t_revision

  task automatic t_compress;
    logic [7:0] exp [4];
    exp = '{8'h77, 8'h77, 8'h77, 8'h11};
    prog(23'h0, 8'h02);
    prog(23'h1, 8'h77);
    prog(23'h2, 8'h00);
    prog(23'h3, 8'h11);
    prog_end;
    comp = 1'b1;
    restart;
    for (int i = 0; i < 4; i++) begin
      tick;
      check(dout, exp[i]);
    end
    comp = 1'b0;
    $display("compress test done");
  endtask : t_compress

  task automatic t_done;
    par = 1'b0;
    for (int k = 0; k < 9; k++) begin
      prog(cbs_bptr_t'(k), 8'(8'h10 + k));
    end
    prog_end;
    restart;
    repeat (64) tick;
    check({7'h0, ceo2_n}, 8'h01);
    check({7'h0, sdo2}, 8'h01);
    tick;
    check({7'h0, ceo2_n}, 8'h00);
    check({7'h0, ceo_n}, 8'h01);
    ce_n = 1'b1;
    #1;
    check({7'h0, ceo2_n}, 8'h01);
    $display("end of image test done");
  endtask : t_done

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_serial;
    t_parallel;
    t_clock;
    t_revision;
    t_compress;
    t_done;
    conclude;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude;
  end
endmodule : cbs_source_test

`default_nettype wire
